// *** hw/asrc_defs.svh ***
// timing and geometry constants for the async sram host controller
`ifndef ASRC_DEFS_SVH
`define ASRC_DEFS_SVH

// ********************************************************************
// geometry
// ********************************************************************
`define ASRC_ADDR_W        16
`define ASRC_DATA_W        16
`define ASRC_LANE_W        8

// ********************************************************************
// timing for the slower speed grade: times in ns, clock in MHz
// ********************************************************************
`define ASRC_CLK_MHZ       40
`define ASRC_T_AA_NS       20
`define ASRC_T_WP_NS       12
`define ASRC_T_HZ_NS       8
`define ASRC_SYNC_STAGES   2

// ********************************************************************
// pin levels while idle (all strobes released)
// ********************************************************************
`define ASRC_STROBES_IDLE  5'h1F

`endif

// *** hw/asrc_pkg.sv ***
// types and helpers for the async sram host controller
`default_nettype none
`include "asrc_defs.svh"

package asrc_pkg;

    // ****************************************************************
    // request and pin carriers
    // ****************************************************************
    typedef struct packed {
        logic                      write;
        logic [1:0]                byte_en;   // bit0 low lane, bit1 high lane
        logic [`ASRC_ADDR_W-1:0]   addr;
        logic [`ASRC_DATA_W-1:0]   wdata;
    } asrc_req_s;

    typedef struct packed {
        logic chip_sel_n;
        logic out_en_n;
        logic write_en_n;
        logic low_byte_enable_n;
        logic high_byte_enable_n;
    } asrc_strobes_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_SETUP,
        ST_RD_ACCESS,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_HOLD,
        ST_TURN
    } asrc_state_e;

    // ****************************************************************
    // least time in ns to whole clock cycles, never below one
    // ****************************************************************
    function automatic int asrc_min_cycles(input int ns);
        int c;
        c = (ns * `ASRC_CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

endpackage

`default_nettype wire

// *** hw/asrc_sync.sv ***
// multi-stage synchroniser for the data lanes read back from the sram pins
`timescale 1ns/1ps
`default_nettype none

module asrc_sync #(
    parameter int WIDTH  = 16,
    parameter int STAGES = 2
) (
    // clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    // data
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] stage [STAGES];

    // shift chain; only the last stage is read outside
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < STAGES; i++) begin
                stage[i] <= '0;
            end
        end else begin
            stage[0] <= d_in;
            for (int i = 1; i < STAGES; i++) begin
                stage[i] <= stage[i-1];
            end
        end
    end

    assign q_out = stage[STAGES-1];

endmodule

`default_nettype wire

// *** hw/asrc_host.sv ***
// host-side controller driving an async 64k x 16 sram with byte lanes
`timescale 1ns/1ps
`default_nettype none
`include "asrc_defs.svh"

module asrc_host
    import asrc_pkg::*;
#(
    parameter int ADDR_W = `ASRC_ADDR_W,
    parameter int DATA_W = `ASRC_DATA_W
) (
    // clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              rst_in,
    // user request port
    input  wire logic              req_valid_in,
    input  wire asrc_req_s         req_in,
    output logic                   req_ready_out,
    // user response port
    output logic                   resp_valid_out,
    output logic [DATA_W-1:0]      resp_rdata_out,
    // sram address and strobes
    output logic [ADDR_W-1:0]      sram_addr_out,
    output logic                   chip_sel_n_out,
    output logic                   out_en_n_out,
    output logic                   write_en_n_out,
    output logic                   low_byte_enable_n_out,
    output logic                   high_byte_enable_n_out,
    // sram low data lane
    input  wire logic [7:0]        data_low_lane_in,
    output logic      [7:0]        data_low_lane_out,
    output logic                   data_low_lane_oe_out,
    // sram high data lane
    input  wire logic [7:0]        data_high_lane_in,
    output logic      [7:0]        data_high_lane_out,
    output logic                   data_high_lane_oe_out
);

    // ****************************************************************
    // cycle counts derived from the sram times in ns
    // ****************************************************************
    localparam int ACC_CYC  = asrc_min_cycles(`ASRC_T_AA_NS);
    localparam int WP_CYC   = asrc_min_cycles(`ASRC_T_WP_NS);
    localparam int HZ_CYC   = asrc_min_cycles(`ASRC_T_HZ_NS);
    localparam int RD_HOLD  = ACC_CYC + `ASRC_SYNC_STAGES;
    localparam logic [3:0] RD_LAST = 4'(RD_HOLD - 1);
    localparam logic [3:0] WP_LAST = 4'(WP_CYC - 1);
    localparam logic [3:0] HZ_LAST = 4'(HZ_CYC - 1);

    asrc_state_e        state;
    asrc_state_e        next_state;
    asrc_req_s          cur;
    asrc_strobes_s      strobes;
    asrc_strobes_s      next_strobes;
    logic [3:0]         cnt;
    logic               cnt_done;
    logic [DATA_W-1:0]  lanes_sync;
    logic               no_lanes;

    // ****************************************************************
    // read-back path through two flip-flops
    // ****************************************************************
    asrc_sync #(
        .WIDTH  (DATA_W),
        .STAGES (`ASRC_SYNC_STAGES)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .d_in        ({data_high_lane_in, data_low_lane_in}),
        .q_out       (lanes_sync)
    );

    // ****************************************************************
    // sequencing
    // ****************************************************************

    // handshake: accept a request only when idle
    assign req_ready_out = (state == ST_IDLE);
    assign no_lanes      = (req_in.byte_en == 2'b00);

    // per-state terminal count
    always_comb begin
        unique case (state)
            ST_RD_ACCESS: cnt_done = (cnt == RD_LAST);
            ST_WR_PULSE:  cnt_done = (cnt == WP_LAST);
            ST_TURN:      cnt_done = (cnt == HZ_LAST);
            default:      cnt_done = 1'b1;
        endcase
    end

    // next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (req_valid_in && !no_lanes) begin
                    next_state = req_in.write ? ST_WR_SETUP : ST_RD_SETUP;
                end
            end
            ST_RD_SETUP:  next_state = ST_RD_ACCESS;
            ST_RD_ACCESS: next_state = cnt_done ? ST_TURN : ST_RD_ACCESS;
            ST_WR_SETUP:  next_state = ST_WR_PULSE;
            ST_WR_PULSE:  next_state = cnt_done ? ST_WR_HOLD : ST_WR_PULSE;
            ST_WR_HOLD:   next_state = ST_IDLE;
            ST_TURN:      next_state = cnt_done ? ST_IDLE : ST_TURN;
        endcase
    end

    // state register
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // dwell counter, cleared on every state change
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt <= '0;
        end else if (next_state != state) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end

    // latch the accepted request
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cur <= '0;
        end else if (state == ST_IDLE && req_valid_in) begin
            cur <= req_in;
        end
    end

    // ****************************************************************
    // sram strobes, registered from the next state
    // ****************************************************************
    always_comb begin
        next_strobes = `ASRC_STROBES_IDLE;
        unique case (next_state)
            ST_RD_ACCESS: begin
                // address already stable one cycle before select falls
                next_strobes.chip_sel_n         = 1'b0;
                next_strobes.out_en_n           = 1'b0;
                next_strobes.low_byte_enable_n  = ~cur.byte_en[0];
                next_strobes.high_byte_enable_n = ~cur.byte_en[1];
            end
            ST_WR_PULSE: begin
                // output enable stays high so the plain pulse width suffices
                next_strobes.chip_sel_n         = 1'b0;
                next_strobes.write_en_n         = 1'b0;
                next_strobes.low_byte_enable_n  = ~cur.byte_en[0];
                next_strobes.high_byte_enable_n = ~cur.byte_en[1];
            end
            default: begin
                next_strobes = `ASRC_STROBES_IDLE;
            end
        endcase
    end

    // strobe register; all strobes rise together to end a write
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            strobes <= `ASRC_STROBES_IDLE;
        end else begin
            strobes <= next_strobes;
        end
    end

    assign chip_sel_n_out         = strobes.chip_sel_n;
    assign out_en_n_out           = strobes.out_en_n;
    assign write_en_n_out         = strobes.write_en_n;
    assign low_byte_enable_n_out  = strobes.low_byte_enable_n;
    assign high_byte_enable_n_out = strobes.high_byte_enable_n;

    // address register, set at the setup state of either access
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sram_addr_out <= '0;
        end else if (state == ST_IDLE && req_valid_in) begin
            sram_addr_out <= req_in.addr[ADDR_W-1:0];
        end
    end

    // ****************************************************************
    // write data drive: only while the sram is floated by a high
    // output enable, and only on lanes being written
    // ****************************************************************
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_low_lane_out     <= '0;
            data_high_lane_out    <= '0;
            data_low_lane_oe_out  <= 1'b0;
            data_high_lane_oe_out <= 1'b0;
        end else begin
            data_low_lane_out  <= cur.wdata[7:0];
            data_high_lane_out <= cur.wdata[15:8];
            if (next_state == ST_WR_PULSE || next_state == ST_WR_HOLD) begin
                data_low_lane_oe_out  <= cur.byte_en[0];
                data_high_lane_oe_out <= cur.byte_en[1];
            end else begin
                data_low_lane_oe_out  <= 1'b0;
                data_high_lane_oe_out <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // responses
    // ****************************************************************

    // read data captured at the end of the access; unread bytes are zero
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            resp_rdata_out <= '0;
        end else if (state == ST_RD_ACCESS && cnt_done) begin
            resp_rdata_out[7:0]  <= cur.byte_en[0] ? lanes_sync[7:0] : 8'h00;
            resp_rdata_out[15:8] <= cur.byte_en[1] ? lanes_sync[15:8] : 8'h00;
        end
    end

    // one-cycle completion pulse for reads, writes and empty requests
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            resp_valid_out <= 1'b0;
        end else begin
            resp_valid_out <= (state == ST_RD_ACCESS && cnt_done)
                           || (state == ST_WR_HOLD)
                           || (state == ST_IDLE && req_valid_in && no_lanes);
        end
    end

endmodule

`default_nettype wire

// *** dv/asrc_host_properties.sv ***
// concurrent checks on the sram pins and responses of the host controller
`timescale 1ns/1ps
`default_nettype none
module asrc_host_properties
    import asrc_pkg::*;
(
    // clock and reset
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    // user side
    input wire logic        req_valid_in,
    input wire asrc_req_s   req_in,
    input wire logic        req_ready_out,
    input wire logic        resp_valid_out,
    // sram side
    input wire logic [15:0] sram_addr_out,
    input wire logic        chip_sel_n_out,
    input wire logic        out_en_n_out,
    input wire logic        write_en_n_out,
    input wire logic        low_byte_enable_n_out,
    input wire logic        high_byte_enable_n_out,
    input wire logic        data_low_lane_oe_out,
    input wire logic        data_high_lane_oe_out
);
    // ****************************************************************
    // pin relations
    // ****************************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // write strobe only inside select and a byte enable
    property p_wr_in; !write_en_n_out |-> !chip_sel_n_out &&
        !(low_byte_enable_n_out && high_byte_enable_n_out); endproperty
    a_wr_in: assert property (p_wr_in) else $error("write outside select");
    // output enable stays off around a write pulse
    property p_wr_oe; !write_en_n_out |-> out_en_n_out && $past(out_en_n_out); endproperty
    a_wr_oe: assert property (p_wr_oe) else $error("oe low in write");
    // lanes driven only with sram outputs off a cycle before
    property p_quiet; data_low_lane_oe_out || data_high_lane_oe_out |->
        out_en_n_out && $past(out_en_n_out); endproperty
    a_quiet: assert property (p_quiet) else $error("lane fight");
    // one cycle pulse, data held one cycle after it
    property p_pulse; $fell(write_en_n_out) |-> ##1 write_en_n_out &&
        (data_low_lane_oe_out || data_high_lane_oe_out); endproperty
    a_pulse: assert property (p_pulse) else $error("bad write pulse");
    // driven lanes follow the byte enables during the pulse
    property p_lanes; !write_en_n_out |-> data_low_lane_oe_out == !low_byte_enable_n_out &&
        data_high_lane_oe_out == !high_byte_enable_n_out; endproperty
    a_lanes: assert property (p_lanes) else $error("lane enable mismatch");
    // address steady and chip selected while reading
    property p_rd_addr; !out_en_n_out |-> !chip_sel_n_out && $stable(sram_addr_out); endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("address moved in read");
    // read strobe lasts three cycles
    property p_rd_len; $fell(out_en_n_out) |-> !out_en_n_out [*3] ##1 out_en_n_out; endproperty
    a_rd_len: assert property (p_rd_len) else $error("read length wrong");
    // write answered four cycles after the take
    property p_wr_resp; req_valid_in && req_ready_out && req_in.write &&
        (req_in.byte_en != 2'h0) |-> ##4 resp_valid_out; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
    // empty request answered at once with no select
    property p_empty; req_valid_in && req_ready_out && (req_in.byte_en == 2'h0) |->
        ##1 resp_valid_out && chip_sel_n_out; endproperty
    a_empty: assert property (p_empty) else $error("empty request accessed");
endmodule
`default_nettype wire

// *** dv/asrc_sram_model.sv ***
// behavioural 64k x 16 async sram with byte lanes
`timescale 1ns/1ps
`default_nettype none
module asrc_sram_model #(
    parameter int ACC_NS = 0
) (
    // address and strobes, levels only
    input  wire logic [15:0] addr_in,
    input  wire logic        cs_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic        lbe_n_in,
    input  wire logic        hbe_n_in,
    // host lane values and drive enables
    input  wire logic [15:0] wdata_in,
    input  wire logic [1:0]  host_oe_in,
    // lanes as the sram leaves them, contention flag
    output logic      [15:0] q_out,
    output logic             clash_out
);
    logic [15:0] mem [0:65535];
    logic [15:0] word;
    logic [15:0] qv;
    logic [15:0] last = 16'hA5C3;
    logic [1:0]  rd;
    logic [1:0]  wr;
    // lanes read out per byte enable
    assign rd = (cs_n_in || oe_n_in || !we_n_in) ? 2'h0
              : ~{hbe_n_in, lbe_n_in};
    assign wr = (cs_n_in || we_n_in) ? 2'h0 : ~{hbe_n_in, lbe_n_in};
    // store enabled bytes during the overlap, other byte untouched
    always @(wr or addr_in or wdata_in) begin
        if (wr[0]) mem[addr_in][7:0] = wdata_in[7:0];
        if (wr[1]) mem[addr_in][15:8] = wdata_in[15:8];
    end
    assign word = mem[addr_in];
    // a released lane shows the inverse of its last value
    always @(rd or word) begin
        if (rd[0]) last[7:0] = word[7:0];
        if (rd[1]) last[15:8] = word[15:8];
    end
    assign qv = {rd[1] ? word[15:8] : ~last[15:8], rd[0] ? word[7:0] : ~last[7:0]};
    assign #(ACC_NS) q_out = qv;
    assign clash_out = |(rd & host_oe_in);
endmodule
`default_nettype wire

// *** dv/test_asrc_host.sv ***
// self-checking bench for the async sram host controller
`timescale 1ns/1ps
`default_nettype none
module test_asrc_host
    import asrc_pkg::*;
;
    // ****************************************************************
    // pins and bench state
    // ****************************************************************
    logic        core_clk_in  = 1'h0;
    logic        rst_in       = 1'h1;
    logic        req_valid_in = 1'h0;
    asrc_req_s   req_in       = '0;
    logic        rdy, rv, cs_n, oe_n, we_n, lbe_n, hbe_n, lo_oe, hi_oe, clash;
    logic [15:0] rdata, addr, q;
    logic [7:0]  lo_o, hi_o, lo_i, hi_i;
    int          err_total = 0;
    int          samples_checked = 0;
    int          cs_low = 0;
    int          clashes = 0;
    always #12.5 core_clk_in = ~core_clk_in;
    asrc_host u_dut (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
        .req_in(req_in), .req_ready_out(rdy), .resp_valid_out(rv), .resp_rdata_out(rdata),
        .sram_addr_out(addr), .chip_sel_n_out(cs_n), .out_en_n_out(oe_n),
        .write_en_n_out(we_n), .low_byte_enable_n_out(lbe_n),
        .high_byte_enable_n_out(hbe_n), .data_low_lane_in(lo_i),
        .data_low_lane_out(lo_o), .data_low_lane_oe_out(lo_oe), .data_high_lane_in(hi_i),
        .data_high_lane_out(hi_o), .data_high_lane_oe_out(hi_oe));
    // slow sram, answers only after the address access time
    asrc_sram_model #(.ACC_NS(20)) u_mem (
        .addr_in(addr), .cs_n_in(cs_n), .oe_n_in(oe_n), .we_n_in(we_n), .lbe_n_in(lbe_n),
        .hbe_n_in(hbe_n), .wdata_in({hi_o, lo_o}), .host_oe_in({hi_oe, lo_oe}),
        .q_out(q), .clash_out(clash));
    // wire level: host drive wins, else what the sram leaves
    assign lo_i = lo_oe ? lo_o : q[7:0];
    assign hi_i = hi_oe ? hi_o : q[15:8];
    // select activity and contention seen at each edge
    always @(posedge core_clk_in) begin
        if (cs_n === 1'h0) cs_low++;
        if (clash === 1'h1) clashes++;
    end
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // one request, answer cycles counted after the take edge
    task automatic op(input logic w, input logic [1:0] be, input logic [15:0] a, d, e);
        int n;
        n = 0;
        // one edge always passes, so valid never falls and rises in one step
        do begin
            @(posedge core_clk_in);
            #2;
            n++;
            if (n > 20) begin
                err_total++;
                close_out();
            end
        end while (rdy !== 1'h1);
        req_in = '{w, be, a, d};
        req_valid_in = 1'h1;
        @(posedge core_clk_in);
        #2;
        req_valid_in = 1'h0;
        n = 0;
        while (rv !== 1'h1) begin
            @(posedge core_clk_in);
            #2;
            n++;
            if (n > 20) begin
                err_total++;
                close_out();
            end
        end
        chk(16'(n), (be == 2'h0) ? 16'h0000 : (w ? 16'h0003 : 16'h0004));
        if (!w && be != 2'h0) chk(rdata, e);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_idle();
        chk({11'h0, cs_n, oe_n, we_n, lbe_n, hbe_n}, 16'h001F);
        chk({13'h0, rdy, lo_oe, hi_oe}, 16'h0004);
    endtask
    task automatic t_word();
        op(1'h1, 2'h3, 16'hFFFF, 16'hA55A, 16'h0000);
        op(1'h1, 2'h3, 16'h0000, 16'h1234, 16'h0000);
        op(1'h0, 2'h3, 16'hFFFF, 16'h0000, 16'hA55A);
        op(1'h0, 2'h3, 16'h0000, 16'h0000, 16'h1234);
    endtask
    task automatic t_bytes();
        op(1'h1, 2'h3, 16'h0100, 16'hBEEF, 16'h0000);
        op(1'h1, 2'h1, 16'h0100, 16'h3412, 16'h0000);
        op(1'h0, 2'h3, 16'h0100, 16'h0000, 16'hBE12);
        op(1'h1, 2'h2, 16'h0100, 16'h5699, 16'h0000);
        op(1'h0, 2'h1, 16'h0100, 16'h0000, 16'h0012);
        op(1'h0, 2'h2, 16'h0100, 16'h0000, 16'h5600);
    endtask
    task automatic t_empty();
        int n;
        n = cs_low;
        op(1'h1, 2'h0, 16'h0300, 16'hFFFF, 16'h0000);
        op(1'h0, 2'h0, 16'h0300, 16'h0000, 16'h0000);
        chk(16'(cs_low - n), 16'h0000);
    endtask
    // reset in the middle of a write pulse, then recover
    task automatic t_midreset();
        op(1'h1, 2'h3, 16'h0200, 16'h7777, 16'h0000);
        req_in = '{1'h1, 2'h3, 16'h0200, 16'h1111};
        req_valid_in = 1'h1;
        @(posedge core_clk_in);
        #2;
        req_valid_in = 1'h0;
        @(posedge core_clk_in);
        #2;
        chk({15'h0, we_n}, 16'h0000);
        rst_in = 1'h1;
        #1;
        t_idle();
        @(posedge core_clk_in);
        #2;
        rst_in = 1'h0;
        op(1'h1, 2'h3, 16'h0200, 16'h1357, 16'h0000);
        op(1'h0, 2'h3, 16'h0200, 16'h0000, 16'h1357);
    endtask
    initial begin
        repeat (10) @(posedge core_clk_in);
        #2;
        t_idle();
        rst_in = 1'h0;
        t_word();
        t_bytes();
        t_empty();
        t_midreset();
        chk(16'(clashes), 16'h0000);
        close_out();
    end
endmodule
bind asrc_host asrc_host_properties u_props (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .req_ready_out(req_ready_out), .resp_valid_out(resp_valid_out),
    .sram_addr_out(sram_addr_out), .chip_sel_n_out(chip_sel_n_out),
    .out_en_n_out(out_en_n_out), .write_en_n_out(write_en_n_out),
    .low_byte_enable_n_out(low_byte_enable_n_out),
    .high_byte_enable_n_out(high_byte_enable_n_out),
    .data_low_lane_oe_out(data_low_lane_oe_out),
    .data_high_lane_oe_out(data_high_lane_oe_out));
`default_nettype wire
